// [logic/cid_pkg.sv]
package cid_pkg;
	localparam int XLEN = 32;
	localparam int AXI_AW = 12;
	localparam int GPR_COUNT = 15;
	// Register map, byte addresses.
	localparam logic [AXI_AW-1:0] ADDR_CTRL = 12'h000;
	localparam logic [AXI_AW-1:0] ADDR_STATUS = 12'h004;
	localparam logic [AXI_AW-1:0] ADDR_GPR_BASE = 12'h040;
	localparam int GPR_SEL_LSB = 6;
	localparam int WORD_LSB = 2;
	localparam int CTRL_RUN_BIT = 0;
	localparam int STATUS_FLAG_LSB = 28;
	localparam int STATUS_STATE_BIT = 5;
	localparam logic CTRL_RUN_RESET = 1'b1;
	localparam logic STATE_RESET = 1'b1;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [XLEN-1:0] GPR_RESET = 32'h0000_0000;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	// Flag positions inside the four-bit flag vector.
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_C = 1;
	localparam int FLAG_V = 0;
	// Instruction fields.
	localparam int F3_TAG_LSB = 13;
	localparam int F3_OP_LSB = 11;
	localparam int F3_DST_LSB = 8;
	localparam int F4_TAG_LSB = 10;
	localparam int F4_OP_LSB = 6;
	localparam int F5_OP_LSB = 8;
	localparam int F5_DBANK_BIT = 7;
	localparam int F5_SBANK_BIT = 6;
	localparam int SRC_LSB = 3;
	localparam int DST_LSB = 0;
	localparam int IMM_LSB = 0;
	localparam int IMM_W = 8;
	localparam logic [2:0] F3_TAG = 3'h1;
	localparam logic [5:0] F4_TAG = 6'h10;
	localparam logic [5:0] F5_TAG = 6'h11;
	localparam logic [1:0] IMM_MOV = 2'h0;
	localparam logic [1:0] IMM_CMP = 2'h1;
	localparam logic [1:0] IMM_ADD = 2'h2;
	localparam logic [1:0] IMM_SUB = 2'h3;
	localparam logic [1:0] HI_ADD = 2'h0;
	localparam logic [1:0] HI_CMP = 2'h1;
	localparam logic [1:0] HI_MOV = 2'h2;
	localparam logic [1:0] HI_XCHG = 2'h3;
	localparam logic [3:0] PC_INDEX = 4'hF;
	localparam logic [XLEN-1:0] PC_AHEAD = 32'h0000_0004;
	localparam logic [7:0] SHIFT_SPAN = 8'h20;
	// Extra cycles beyond the single issue cycle.
	localparam logic [2:0] CYC_NONE = 3'h0;
	localparam logic [2:0] CYC_LAST = 3'h1;
	localparam logic [2:0] CYC_SHIFT_EXTRA = 3'h1;
	localparam logic [2:0] CYC_BRANCH_EXTRA = 3'h2;
	localparam logic [2:0] CYC_MUL_M1 = 3'h1;
	localparam logic [2:0] CYC_MUL_M2 = 3'h2;
	localparam logic [2:0] CYC_MUL_M3 = 3'h3;
	localparam logic [2:0] CYC_MUL_M4 = 3'h4;

	// The low sixteen codes equal the two-register class operation field.
	typedef enum logic [4:0] {
		ALU_AND = 5'b00000, ALU_XOR = 5'b00001, ALU_SHL = 5'b00010,
		ALU_SHR = 5'b00011, ALU_SAR = 5'b00100, ALU_ADDC = 5'b00101,
		ALU_SUBC = 5'b00110, ALU_ROTR = 5'b00111, ALU_ANDTEST = 5'b01000,
		ALU_NEGATE = 5'b01001, ALU_CMP = 5'b01010, ALU_ADDCMP = 5'b01011,
		ALU_OR = 5'b01100, ALU_MULT = 5'b01101, ALU_BITCLR = 5'b01110,
		ALU_INVMOV = 5'b01111, ALU_MOV = 5'b10000, ALU_ADD = 5'b10001,
		ALU_SUB = 5'b10010
	} cid_aluop_t;

	typedef enum logic [0:0] {ST_READY = 1'b0, ST_STALL = 1'b1} cid_fsm_t;
endpackage

// [logic/cid_alu_if.sv]
`timescale 1ns/1ns
interface cid_alu_if;
	import cid_pkg::*;
	cid_aluop_t op;
	logic [XLEN-1:0] a;
	logic [XLEN-1:0] b;
	logic cin;
	logic vin;
	logic [XLEN-1:0] result;
	logic n;
	logic z;
	logic c;
	logic v;
	modport ctl (output op, a, b, cin, vin, input result, n, z, c, v);
	modport alu (input op, a, b, cin, vin, output result, n, z, c, v);
endinterface

// [logic/cid_alu.sv]
`timescale 1ns/1ns
module cid_alu
	import cid_pkg::*;
(
	// Operands in, result and flags out.
	cid_alu_if.alu alu_bus
);
	logic [XLEN-1:0] add_a;
	logic [XLEN-1:0] add_b;
	logic add_cin;
	logic [XLEN:0] sum;
	logic sum_v;
	logic [7:0] amt;
	logic [4:0] amt_lo;
	logic amt_zero;
	logic amt_lt32;
	logic amt_eq32;
	logic [XLEN-1:0] shl_r;
	logic [XLEN-1:0] shr_r;
	logic [XLEN-1:0] sar_r;
	logic [XLEN-1:0] ror_r;
	logic [2*XLEN-1:0] ror_wide;
	logic shl_c;
	logic shr_c;
	logic sar_c;
	logic ror_c;
	logic [XLEN-1:0] res;
	logic c_out;
	logic v_out;

	assign amt = alu_bus.b[7:0];
	assign amt_lo = amt[4:0];
	assign amt_zero = amt == 8'h00;
	assign amt_lt32 = amt < SHIFT_SPAN;
	assign amt_eq32 = amt == SHIFT_SPAN;

	assign shl_r = amt_lt32 ? (alu_bus.a << amt_lo) : '0;
	assign shr_r = amt_lt32 ? (alu_bus.a >> amt_lo) : '0;
	assign sar_r = amt_lt32 ? XLEN'($signed(alu_bus.a) >>> amt_lo) : {XLEN{alu_bus.a[XLEN-1]}};
	assign ror_wide = {alu_bus.a, alu_bus.a} >> amt_lo;
	assign ror_r = ror_wide[XLEN-1:0];
	assign shl_c = amt_zero ? alu_bus.cin :
		amt_lt32 ? alu_bus.a[5'(SHIFT_SPAN - {3'h0, amt_lo})] :
		amt_eq32 ? alu_bus.a[0] : 1'b0;
	assign shr_c = amt_zero ? alu_bus.cin :
		amt_lt32 ? alu_bus.a[amt_lo - 5'h1] :
		amt_eq32 ? alu_bus.a[XLEN-1] : 1'b0;
	assign sar_c = amt_zero ? alu_bus.cin :
		amt_lt32 ? alu_bus.a[amt_lo - 5'h1] : alu_bus.a[XLEN-1];
	assign ror_c = amt_zero ? alu_bus.cin : ror_r[XLEN-1];

	always_comb begin
		add_a = alu_bus.a;
		add_b = alu_bus.b;
		add_cin = 1'b0;
		case (alu_bus.op)
			ALU_ADDC: add_cin = alu_bus.cin;
			ALU_SUBC: begin
				add_b = ~alu_bus.b;
				add_cin = alu_bus.cin;
			end
			ALU_SUB, ALU_CMP: begin
				add_b = ~alu_bus.b;
				add_cin = 1'b1;
			end
			ALU_NEGATE: begin
				add_a = '0;
				add_b = ~alu_bus.b;
				add_cin = 1'b1;
			end
			default: add_cin = 1'b0;
		endcase
	end

	assign sum = {1'b0, add_a} + {1'b0, add_b} + {{XLEN{1'b0}}, add_cin};
	assign sum_v = (add_a[XLEN-1] == add_b[XLEN-1]) && (sum[XLEN-1] != add_a[XLEN-1]);

	// Logical, move and multiply results keep carry and overflow as they were.
	always_comb begin
		res = sum[XLEN-1:0];
		c_out = sum[XLEN];
		v_out = sum_v;
		case (alu_bus.op)
			ALU_AND, ALU_ANDTEST: res = alu_bus.a & alu_bus.b;
			ALU_XOR: res = alu_bus.a ^ alu_bus.b;
			ALU_OR: res = alu_bus.a | alu_bus.b;
			ALU_BITCLR: res = alu_bus.a & ~alu_bus.b;
			ALU_INVMOV: res = ~alu_bus.b;
			ALU_MOV: res = alu_bus.b;
			ALU_MULT: res = alu_bus.a * alu_bus.b;
			ALU_SHL: res = shl_r;
			ALU_SHR: res = shr_r;
			ALU_SAR: res = sar_r;
			ALU_ROTR: res = ror_r;
			default: res = sum[XLEN-1:0];
		endcase
		case (alu_bus.op)
			ALU_AND, ALU_ANDTEST, ALU_XOR, ALU_OR, ALU_BITCLR, ALU_INVMOV, ALU_MOV,
			ALU_MULT: begin
				c_out = alu_bus.cin;
				v_out = alu_bus.vin;
			end
			ALU_SHL: begin
				c_out = shl_c;
				v_out = alu_bus.vin;
			end
			ALU_SHR: begin
				c_out = shr_c;
				v_out = alu_bus.vin;
			end
			ALU_SAR: begin
				c_out = sar_c;
				v_out = alu_bus.vin;
			end
			ALU_ROTR: begin
				c_out = ror_c;
				v_out = alu_bus.vin;
			end
			default: c_out = sum[XLEN];
		endcase
	end

	assign alu_bus.result = res;
	assign alu_bus.n = res[XLEN-1];
	assign alu_bus.z = res == '0;
	assign alu_bus.c = c_out;
	assign alu_bus.v = v_out;
endmodule

// [logic/cid_decode.sv]
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module cid_decode
	import cid_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic sys_rst,
	// AXI4-Lite register port.
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [XLEN-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [XLEN-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Instruction words from the fetch stage.
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [XLEN-1:0] instr_addr,
	output logic instr_ready,
	// Redirect toward the fetch stage.
	output logic branch_valid,
	output logic [XLEN-1:0] branch_target,
	output logic branch_state,
	// Processor status.
	output logic [3:0] cond_flags,
	output logic compressed_state
);
	cid_alu_if alu_bus ();

	cid_fsm_t fsm_reg;
	cid_fsm_t fsm_next;
	logic [2:0] stall_reg;
	logic [2:0] stall_next;
	logic [XLEN-1:0] gpr_reg [0:GPR_COUNT-1];
	logic [3:0] nzcv_reg;
	logic state_reg;
	logic run_reg;
	logic [XLEN-1:0] target_reg;
	logic branch_valid_reg;

	logic is_imm;
	logic is_alu;
	logic is_hi;
	logic [1:0] imm_op;
	logic [3:0] alu_code;
	logic [1:0] hi_op;
	logic dest_bank_flag;
	logic src_bank_flag;
	logic [IMM_W-1:0] imm_byte_field;
	logic [3:0] dst_idx;
	logic [3:0] src_idx;
	logic [XLEN-1:0] pc_sum;
	logic [XLEN-1:0] pc_operand;
	logic [XLEN-1:0] dst_val;
	logic [XLEN-1:0] src_val;
	cid_aluop_t sel_op;
	logic is_cmp_like;
	logic is_exch;
	logic pc_dest;
	logic is_shift;
	logic is_mult;
	logic take;
	logic wb_en;
	logic flags_en;
	logic redirect_sel;
	logic redirect;
	logic [XLEN-1:0] redirect_addr;
	logic mul_m1;
	logic mul_m2;
	logic mul_m3;
	logic [2:0] mul_extra;
	logic [2:0] extra;

	logic aw_held_reg;
	logic w_held_reg;
	logic [AXI_AW-1:0] aw_addr_reg;
	logic [XLEN-1:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [XLEN-1:0] rdata_reg;
	logic do_write;
	logic [XLEN-1:0] wmask;
	logic wr_ctrl;
	logic wr_status;
	logic wr_gpr_area;
	logic [3:0] wr_idx;
	logic gpr_we;
	logic [XLEN-1:0] gpr_merged;
	logic rd_ctrl;
	logic rd_status;
	logic rd_gpr_area;
	logic [3:0] rd_idx;
	logic [XLEN-1:0] status_word;
	logic [XLEN-1:0] rd_word;
	logic ar_take;

	cid_alu u_alu (
		.alu_bus(alu_bus)
	);

	// Field decode.
	assign is_imm = instr_word[F3_TAG_LSB +: 3] == F3_TAG;
	assign is_alu = instr_word[F4_TAG_LSB +: 6] == F4_TAG;
	assign is_hi = instr_word[F4_TAG_LSB +: 6] == F5_TAG;
	assign imm_op = instr_word[F3_OP_LSB +: 2];
	assign alu_code = instr_word[F4_OP_LSB +: 4];
	assign hi_op = instr_word[F5_OP_LSB +: 2];
	assign dest_bank_flag = instr_word[F5_DBANK_BIT];
	assign src_bank_flag = instr_word[F5_SBANK_BIT];
	assign imm_byte_field = instr_word[IMM_LSB +: IMM_W];
	assign dst_idx = is_imm ? {1'b0, instr_word[F3_DST_LSB +: 3]} :
		{is_hi & dest_bank_flag, instr_word[DST_LSB +: 3]};
	assign src_idx = {is_hi & src_bank_flag, instr_word[SRC_LSB +: 3]};

	assign pc_sum = instr_addr + PC_AHEAD;
	assign pc_operand = {pc_sum[XLEN-1:1], 1'b0};
	assign dst_val = (dst_idx == PC_INDEX) ? pc_operand : gpr_reg[dst_idx];
	assign src_val = (src_idx == PC_INDEX) ? pc_operand : gpr_reg[src_idx];

	always_comb begin
		sel_op = ALU_MOV;
		if (is_imm) begin
			unique case (imm_op)
				IMM_MOV: sel_op = ALU_MOV;
				IMM_CMP: sel_op = ALU_CMP;
				IMM_ADD: sel_op = ALU_ADD;
				IMM_SUB: sel_op = ALU_SUB;
			endcase
		end else if (is_alu) begin
			sel_op = cid_aluop_t'({1'b0, alu_code});
		end else if (hi_op == HI_ADD) begin
			sel_op = ALU_ADD;
		end else if (hi_op == HI_CMP) begin
			sel_op = ALU_CMP;
		end
	end

	assign alu_bus.op = sel_op;
	assign alu_bus.a = dst_val;
	assign alu_bus.b = is_imm ? {{(XLEN-IMM_W){1'b0}}, imm_byte_field} : src_val;
	assign alu_bus.cin = nzcv_reg[FLAG_C];
	assign alu_bus.vin = nzcv_reg[FLAG_V];

	assign is_cmp_like = (sel_op == ALU_ANDTEST) || (sel_op == ALU_CMP) ||
		(sel_op == ALU_ADDCMP);
	assign is_exch = is_hi && (hi_op == HI_XCHG);
	assign pc_dest = is_hi && !is_exch && !is_cmp_like && (dst_idx == PC_INDEX);
	assign is_shift = is_alu && ((sel_op == ALU_SHL) || (sel_op == ALU_SHR) ||
		(sel_op == ALU_SAR) || (sel_op == ALU_ROTR));
	assign is_mult = is_alu && (sel_op == ALU_MULT);

	assign take = instr_valid && instr_ready;
	assign wb_en = take && (is_imm || is_alu || is_hi) && !is_cmp_like && !is_exch && !pc_dest;
	assign flags_en = take && (is_imm || is_alu || (is_hi && hi_op == HI_CMP));
	assign redirect_sel = is_exch || pc_dest;
	assign redirect = take && redirect_sel;
	assign redirect_addr = is_exch ? {src_val[XLEN-1:1], 1'b0} :
		{alu_bus.result[XLEN-1:1], 1'b0};

	// Multiplier early termination follows the sign-run of the multiplier operand.
	assign mul_m1 = (&dst_val[XLEN-1:8]) || !(|dst_val[XLEN-1:8]);
	assign mul_m2 = (&dst_val[XLEN-1:16]) || !(|dst_val[XLEN-1:16]);
	assign mul_m3 = (&dst_val[XLEN-1:24]) || !(|dst_val[XLEN-1:24]);
	assign mul_extra = mul_m1 ? CYC_MUL_M1 : mul_m2 ? CYC_MUL_M2 :
		mul_m3 ? CYC_MUL_M3 : CYC_MUL_M4;
	assign extra = redirect_sel ? CYC_BRANCH_EXTRA : is_mult ? mul_extra :
		is_shift ? CYC_SHIFT_EXTRA : CYC_NONE;

	always_comb begin
		fsm_next = fsm_reg;
		stall_next = stall_reg;
		unique case (fsm_reg)
			ST_READY: begin
				if (take && extra != CYC_NONE) begin
					fsm_next = ST_STALL;
					stall_next = extra;
				end
			end
			ST_STALL: begin
				stall_next = stall_reg - 3'h1;
				if (stall_reg == CYC_LAST) begin
					fsm_next = ST_READY;
				end
			end
		endcase
	end

	// Words are only taken in the compressed state; a switch away parks the block.
	assign instr_ready = run_reg && state_reg && (fsm_reg == ST_READY);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fsm_reg <= ST_READY;
			stall_reg <= CYC_NONE;
		end else begin
			fsm_reg <= fsm_next;
			stall_reg <= stall_next;
		end
	end

	// Register bus decode.
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign do_write = aw_held_reg && w_held_reg;
	assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
		{8{w_strb_reg[0]}}};
	assign wr_ctrl = aw_addr_reg[AXI_AW-1:WORD_LSB] == ADDR_CTRL[AXI_AW-1:WORD_LSB];
	assign wr_status = aw_addr_reg[AXI_AW-1:WORD_LSB] == ADDR_STATUS[AXI_AW-1:WORD_LSB];
	assign wr_gpr_area = aw_addr_reg[AXI_AW-1:GPR_SEL_LSB] ==
		ADDR_GPR_BASE[AXI_AW-1:GPR_SEL_LSB];
	assign wr_idx = aw_addr_reg[WORD_LSB +: 4];
	assign gpr_we = do_write && wr_gpr_area && (wr_idx != PC_INDEX);
	assign gpr_merged = (gpr_reg[wr_idx] & ~wmask) | (w_data_reg & wmask);

	assign ar_take = s_axi_arvalid && !rvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign rd_ctrl = s_axi_araddr[AXI_AW-1:WORD_LSB] == ADDR_CTRL[AXI_AW-1:WORD_LSB];
	assign rd_status = s_axi_araddr[AXI_AW-1:WORD_LSB] == ADDR_STATUS[AXI_AW-1:WORD_LSB];
	assign rd_gpr_area = s_axi_araddr[AXI_AW-1:GPR_SEL_LSB] ==
		ADDR_GPR_BASE[AXI_AW-1:GPR_SEL_LSB];
	assign rd_idx = s_axi_araddr[WORD_LSB +: 4];

	always_comb begin
		status_word = '0;
		status_word[STATUS_FLAG_LSB +: 4] = nzcv_reg;
		status_word[STATUS_STATE_BIT] = state_reg;
	end

	assign rd_word = rd_ctrl ? {{(XLEN-1){1'b0}}, run_reg} : rd_status ? status_word :
		!rd_gpr_area ? '0 : (rd_idx == PC_INDEX) ? target_reg : gpr_reg[rd_idx];

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= (wr_ctrl || wr_status || wr_gpr_area) ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rvalid_reg <= 1'b0;
			rresp_reg <= AXI_OKAY;
			rdata_reg <= '0;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= (rd_ctrl || rd_status || rd_gpr_area) ? AXI_OKAY : AXI_SLVERR;
			rdata_reg <= rd_word;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Instruction writeback lands after a bus write to the same register.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < GPR_COUNT; i++) begin
				gpr_reg[i] <= GPR_RESET;
			end
		end else begin
			if (gpr_we) begin
				gpr_reg[wr_idx] <= gpr_merged;
			end
			if (wb_en) begin
				gpr_reg[dst_idx] <= alu_bus.result;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_reg <= CTRL_RUN_RESET;
			nzcv_reg <= FLAGS_RESET;
			state_reg <= STATE_RESET;
			target_reg <= '0;
			branch_valid_reg <= 1'b0;
		end else begin
			if (do_write && wr_ctrl && w_strb_reg[0]) begin
				run_reg <= w_data_reg[CTRL_RUN_BIT];
			end
			if (do_write && wr_status && w_strb_reg[3]) begin
				nzcv_reg <= w_data_reg[STATUS_FLAG_LSB +: 4];
			end
			if (do_write && wr_status && w_strb_reg[0]) begin
				state_reg <= w_data_reg[STATUS_STATE_BIT];
			end
			if (flags_en) begin
				nzcv_reg <= {alu_bus.n, alu_bus.z, alu_bus.c, alu_bus.v};
			end
			branch_valid_reg <= redirect;
			if (redirect) begin
				target_reg <= redirect_addr;
			end
			if (redirect && is_exch) begin
				state_reg <= src_val[0];
			end
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign branch_valid = branch_valid_reg;
	assign branch_target = target_reg;
	assign branch_state = state_reg;
	assign cond_flags = nzcv_reg;
	assign compressed_state = state_reg;
endmodule

// [verification/cid_decode_chk.sv]
`timescale 1ns/1ns
module cid_decode_chk
	import cid_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Instruction port and status.
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic instr_ready,
	input wire logic branch_valid,
	input wire logic [XLEN-1:0] branch_target,
	input wire logic branch_state,
	input wire logic [3:0] cond_flags,
	input wire logic compressed_state
);
	wire taken = instr_valid && instr_ready;
	wire [3:0] op4 = instr_word[9:6];
	wire is_imm = taken && instr_word[15:13] == F3_TAG;
	wire is_alu = taken && instr_word[15:10] == F4_TAG;
	wire is_shift = is_alu && op4 inside {4'h2, 4'h3, 4'h4, 4'h7};
	wire is_hi = taken && instr_word[15:10] == F5_TAG;
	wire is_xchg = is_hi && instr_word[9:8] == HI_XCHG;
	wire hi_quiet = is_hi && !instr_word[8];
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	chk_shift_stall: assert property (is_shift |=> !instr_ready ##1 instr_ready)
		else $error("register shift stall is not one cycle");
	chk_imm_single: assert property (is_imm |=> instr_ready)
		else $error("immediate instruction stalled");
	chk_xchg_pulse: assert property (
		is_xchg |=> branch_valid && !instr_ready ##1 !branch_valid && !instr_ready)
		else $error("exchange redirect or stall wrong");
	chk_target_align: assert property (branch_valid |-> !branch_target[0])
		else $error("branch target bit 0 set");
	chk_state_match: assert property (
		branch_valid |-> branch_state == compressed_state && (compressed_state || !instr_ready))
		else $error("branch state differs from status or block not parked");
	chk_hi_flags: assert property (hi_quiet |=> $stable(cond_flags))
		else $error("high add or move touched flags");
	chk_mov_flags: assert property (
		is_imm && instr_word[12:11] == IMM_MOV |=> cond_flags[3:2] == {1'b0,
		$past(instr_word[7:0]) == 8'h00} && cond_flags[1:0] == $past(cond_flags[1:0]))
		else $error("immediate move flags wrong");
	chk_redirect_cause: assert property ($rose(branch_valid) |-> $past(taken))
		else $error("redirect without an instruction");
endmodule

// [verification/cid_fetch_model.sv]
`timescale 1ns/1ns
module cid_fetch_model
	import cid_pkg::*;
(
	// Clock.
	input wire logic ref_clk,
	// Handshake with the decoder.
	input wire logic instr_ready,
	output logic instr_valid,
	output logic [15:0] instr_word,
	output logic [XLEN-1:0] instr_addr
);
	initial begin
		instr_valid = 1'b0;
		instr_word = 16'hffff;
		instr_addr = 32'hffff_ffff;
	end
	// Released lines show the inverse so stale words never look valid.
	task automatic issue(input logic [15:0] w, input logic [XLEN-1:0] a, input int idle,
		output bit ok);
		int n;
		n = 0;
		repeat (idle) @(posedge ref_clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		instr_addr <= a;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!instr_ready && n < 40);
		ok = instr_ready;
		instr_valid <= 1'b0;
		instr_word <= ~w;
		instr_addr <= ~a;
	endtask
endmodule

// [verification/tb_compact_isa_alu_hireg_decode.sv]
`timescale 1ns/1ns
module tb_compact_isa_alu_hireg_decode;
	import cid_pkg::*;
	logic ref_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic instr_valid, instr_ready, branch_valid, branch_state, compressed_state;
	logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [XLEN-1:0] s_axi_wdata, s_axi_rdata, instr_addr, branch_target, pc;
	logic [XLEN-1:0] rf [0:15];
	logic [3:0] s_axi_wstrb, cond_flags, fl;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] instr_word;
	logic [33:0] rd_q[$];
	logic [32:0] br_q[$];
	logic [1:0] wr_q[$];
	logic st;
	bit ok;
	int errors, checks_done;
	cid_decode u_cid_decode (.ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .instr_valid(instr_valid), .instr_word(instr_word),
		.instr_addr(instr_addr), .instr_ready(instr_ready), .branch_valid(branch_valid),
		.branch_target(branch_target), .branch_state(branch_state), .cond_flags(cond_flags),
		.compressed_state(compressed_state));
	cid_fetch_model u_cid_fetch_model (.ref_clk(ref_clk), .instr_ready(instr_ready),
		.instr_valid(instr_valid), .instr_word(instr_word), .instr_addr(instr_addr));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic report_and_stop();
		$display("TB: errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic give_up();
		errors++;
		report_and_stop();
	endtask
	task automatic cmp_read(input logic [33:0] exp, input logic [33:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] bus read exp %h got %h", exp, got);
		end
	endtask
	task automatic cmp_branch(input logic [32:0] exp, input logic [32:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] redirect exp %h got %h", exp, got);
		end
	endtask
	task automatic cmp_resp(input logic [1:0] exp, input logic [1:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] write resp exp %h got %h", exp, got);
		end
	endtask
	always @(posedge ref_clk) begin
		if (s_axi_rvalid && s_axi_rready)
			cmp_read(rd_q.size() > 0 ? rd_q.pop_front() : 'x, {s_axi_rresp, s_axi_rdata});
		if (branch_valid)
			cmp_branch(br_q.size() > 0 ? br_q.pop_front() : 'x, {branch_target, branch_state});
		if (s_axi_bvalid && s_axi_bready)
			cmp_resp(wr_q.size() > 0 ? wr_q.pop_front() : 'x, s_axi_bresp);
	end
	function automatic logic [AXI_AW-1:0] gaddr(input int i);
		return ADDR_GPR_BASE + AXI_AW'(i * 4);
	endfunction
	function automatic logic [33:0] stat();
		return {AXI_OKAY, fl, 22'h00_0000, st, 5'h00};
	endfunction
	function automatic logic [XLEN-1:0] opv(input logic [3:0] i);
		return i == PC_INDEX ? (pc + PC_AHEAD) & 32'hffff_fffe : rf[i];
	endfunction
	function automatic logic [35:0] addf(input logic [31:0] a, input logic [31:0] b, input logic ci);
		logic [32:0] t;
		t = {1'b0, a} + {1'b0, b} + 33'(ci);
		return {t[31], t[31:0] == 32'h0000_0000, t[32], a[31] == b[31] && t[31] != a[31], t[31:0]};
	endfunction
	function automatic logic [35:0] alu_ref(input logic [3:0] op, input logic [31:0] a, b);
		logic [31:0] r;
		logic c;
		int s;
		s = b[7:0];
		c = fl[FLAG_C];
		case (op)
			4'h0, 4'h8: r = a & b;
			4'h1: r = a ^ b;
			4'h2: r = a << s;
			4'h3: r = a >> s;
			4'h4: r = $signed(a) >>> s;
			4'h5: return addf(a, b, fl[FLAG_C]);
			4'h6: return addf(a, ~b, fl[FLAG_C]);
			4'h7: r = (a >> s) | (a << (32 - s));
			4'h9: return addf(32'h0000_0000, ~b, 1'b1);
			4'ha: return addf(a, ~b, 1'b1);
			4'hb: return addf(a, b, 1'b0);
			4'hc: r = a | b;
			4'hd: r = a * b;
			4'he: r = a & ~b;
			default: r = ~b;
		endcase
		if (op inside {4'h2, 4'h3, 4'h4, 4'h7})
			c = (op == 4'h2) ? a[32 - s] : a[s - 1];
		return {r[31], r == 32'h0000_0000, c, fl[FLAG_V], r};
	endfunction
	task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [XLEN-1:0] d, input logic [3:0] s);
		int n;
		bit aw_p, w_p;
		n = 0;
		aw_p = 1'b1;
		w_p = 1'b1;
		wr_q.push_back(AXI_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			aw_p = aw_p && !s_axi_awready;
			w_p = w_p && !s_axi_wready;
		end while ((aw_p || w_p) && n < 40);
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!s_axi_bvalid && n < 80);
		s_axi_bready <= 1'b0;
		if (n >= 80)
			give_up();
	endtask
	task automatic axi_rd(input logic [AXI_AW-1:0] a, input logic [33:0] exp);
		int n;
		n = 0;
		rd_q.push_back(exp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 40);
		if (n >= 40)
			give_up();
	endtask
	task automatic step(input logic [15:0] w, input int d, input logic [35:0] fr, input bit wr);
		u_cid_fetch_model.issue(w, pc, $urandom_range(2), ok);
		if (!ok)
			give_up();
		pc = pc + 32'h0000_0002;
		fl = fr[35:32];
		if (wr)
			rf[d] = fr[31:0];
		axi_rd(gaddr(d), {AXI_OKAY, rf[d]});
		axi_rd(ADDR_STATUS, stat());
	endtask
	initial begin
		logic [2:0] d, s;
		logic [1:0] o;
		logic [3:0] a;
		logic [35:0] fr;
		logic [31:0] v;
		logic h1, h2;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h01;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		sys_rst = 1'b1;
		pc = 32'h0000_1000;
		fl = FLAGS_RESET;
		st = STATE_RESET;
		void'($urandom(32'haf626363));
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		axi_rd(ADDR_CTRL, {AXI_OKAY, 32'h0000_0001});
		axi_rd(ADDR_STATUS, stat());
		axi_rd(12'h100, {AXI_SLVERR, 32'h0000_0000});
		for (int i = 0; i < GPR_COUNT; i++) begin
			rf[i] = $urandom();
			axi_rd(gaddr(i), {AXI_OKAY, GPR_RESET});
			axi_wr(gaddr(i), rf[i], 4'hf);
		end
		for (int k = 0; k < 16; k++) begin
			o = k[1:0];
			d = 3'($urandom_range(7));
			v = 32'($urandom_range(255));
			fr = alu_ref(o == IMM_MOV ? 4'hf : o == IMM_ADD ? 4'hb : 4'ha, rf[d], o ? v : ~v);
			step({F3_TAG, o, d, v[7:0]}, d, fr, o != IMM_CMP);
		end
		for (int k = 0; k < 32; k++) begin
			a = k[3:0];
			d = 3'($urandom_range(7));
			s = 3'($urandom_range(7));
			v = $urandom();
			if (a inside {4'h2, 4'h3, 4'h4, 4'h7})
				v[7:0] = 8'($urandom_range(31, 1));
			axi_wr(gaddr(s), v, 4'hf);
			rf[s] = v;
			fl = 4'($urandom());
			axi_wr(ADDR_STATUS, {fl, 28'h000_0000}, 4'h8);
			fr = alu_ref(a, rf[d], rf[s]);
			step({F4_TAG, a, s, d}, d, fr, !(a inside {4'h8, 4'ha, 4'hb}));
		end
		for (int k = 0; k < 9; k++) begin
			o = 2'(k / 3);
			{h1, h2} = 2'(k % 3 + 1);
			d = 3'($urandom_range(h1 ? 6 : 7));
			s = k == 0 ? 3'h7 : 3'($urandom_range(7));
			fr = {fl, o == HI_ADD ? opv({h1, d}) + opv({h2, s}) : opv({h2, s})};
			if (o == HI_CMP)
				fr = alu_ref(4'ha, opv({h1, d}), opv({h2, s}));
			step({F5_TAG, o, h1, h2, s, d}, {h1, d}, fr, o != HI_CMP);
		end
		for (int k = 0; k < 2; k++) begin
			v = $urandom();
			v[0] = !k[0];
			axi_wr(gaddr(k * 8 + 1), v, 4'hf);
			rf[k * 8 + 1] = v;
			br_q.push_back({v & 32'hffff_fffe, v[0]});
			st = v[0];
			u_cid_fetch_model.issue({F5_TAG, HI_XCHG, 1'b0, k[0], 6'h08}, pc, 0, ok);
			if (!ok)
				give_up();
			pc = v & 32'hffff_fffe;
			axi_rd(ADDR_STATUS, stat());
		end
		axi_wr(ADDR_STATUS, 32'h0000_0020, 4'h1);
		st = 1'b1;
		step({F3_TAG, IMM_MOV, 3'h2, 8'h00}, 2, alu_ref(4'hf, rf[2], 32'hffff_ffff), 1'b1);
		report_and_stop();
	end
endmodule
bind cid_decode cid_decode_chk u_cid_decode_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
	.branch_valid(branch_valid), .branch_target(branch_target), .branch_state(branch_state),
	.cond_flags(cond_flags), .compressed_state(compressed_state));
